/* design/rct_timers.sv */
// Reload/capture timer with trigger input and slow-clock time-base timer, APB slave
// How it works
// RULE_01 - Overflow sets overflow flag unless a serial clock select is set; software clears
// RULE_02 - Trigger-caused capture or reload sets trigger flag when enabled; software clears
// RULE_03 - Receive select picks reload timer or second timer overflow as receive clock
// RULE_04 - Transmit select picks reload timer or second timer overflow as transmit clock
// RULE_05 - Trigger falling edge acts only when enabled and both serial selects are zero
// RULE_06 - Timer mode counts every two system clocks while running, else holds
// RULE_07 - Counter mode counts on negative edges of the selected count input
// RULE_08 - Reload mode reloads on overflow and on enabled trigger falling edges
// RULE_09 - Capture mode captures count on enabled trigger falling edges
// RULE_10 - Any serial select forces reload on overflow, ignoring capture select
// RULE_11 - Reload copies reload pair into counter; capture copies counter into pair
// RULE_12 - Reload input select: count pin at zero, slow clock over 16 at one
// RULE_13 - Second timer input select: its pin at zero, slow clock over 16 at one
// RULE_14 - Time-base timer runs from the slow clock input
// RULE_15 - Time-base period 32768, 16384, 8192 or 128 slow cycles by rate code
// RULE_16 - Time-base flag sets at period end; clears on service entry acknowledge
// RULE_17 - Software clears time-base flag alone by writing FEh to interrupt flags
// RULE_18 - Writing one to time-base clear restarts its count; bit self-clears next cycle
// RULE_19 - Counter is one 16-bit value; overflow on all ones to zero
// RULE_20 - Buzzer wave toggles on each overflow, giving overflow rate over two
// RULE_21 - Serial baud tick from reload timer is its overflow rate over 16
`timescale 1ns/1ps
module rct_timers
	import rct_pkg::*;
#(
	parameter logic [3:0] BAUD_LAST = RCT_BAUD_DIV_LAST
) (
	input wire logic clk, // System clock, 20 MHz
	input wire logic rstn, // Asynchronous reset, active low
	input wire rct_apb_req_t apb_req, // APB request
	output rct_apb_rsp_t apb_rsp, // APB answer
	input wire logic slow_clock, // Slow oscillator clock, sampled
	input wire logic trigger_input_pin, // Trigger pin, falling edge acts
	input wire logic reload_count_pin, // External count pin of the reload timer
	input wire logic second_count_pin, // External count pin of the second timer
	input wire logic second_timer_overflow, // Overflow pulse of the second timer
	input wire logic timebase_isr_ack, // Pulse on time-base service entry
	input wire logic [2:0] other_flag_set, // Set pulses for touch, convert, port flags
	output logic serial_rx_clock, // Selected receive overflow pulse
	output logic serial_tx_clock, // Selected transmit overflow pulse
	output logic serial_rx_baud, // Reload overflow over 16 for receive
	output logic serial_tx_baud, // Reload overflow over 16 for transmit
	output logic second_count_tick, // Count pulse for the second timer
	output logic buzzer_wave_output, // Overflow over two waveform
	output logic reload_overflow_flag, // Overflow flag level
	output logic external_trigger_flag, // Trigger flag level
	output logic timebase_flag // Time-base flag level
);

	rct_state_t st;
	rct_state_t next_st;

	// Bus decode
	logic access;
	logic wr;
	logic rd_setup;
	logic [9:0] idx;
	logic hit;
	logic wr_opt;
	logic wr_flg;
	logic wr_ctl;
	logic wr_vl;
	logic wr_vh;
	logic wr_cl;
	logic wr_ch;
	logic wr_aux;

	assign access = apb_req.psel & apb_req.penable;
	assign wr = access & apb_req.pwrite;
	assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
	assign idx = apb_req.paddr[RCT_ADDR_W-1:2];
	assign hit = (idx == RCT_IDX_OPTION_SETTINGS) | (idx == RCT_IDX_INTERRUPT_FLAGS)
		| (idx == RCT_IDX_RELOAD_TIMER_CONTROL) | (idx == RCT_IDX_RELOAD_VALUE_LOW)
		| (idx == RCT_IDX_RELOAD_VALUE_HIGH) | (idx == RCT_IDX_RELOAD_COUNT_LOW)
		| (idx == RCT_IDX_RELOAD_COUNT_HIGH) | (idx == RCT_IDX_AUXILIARY_CONTROL);
	assign wr_opt = wr & (idx == RCT_IDX_OPTION_SETTINGS);
	assign wr_flg = wr & (idx == RCT_IDX_INTERRUPT_FLAGS);
	assign wr_ctl = wr & (idx == RCT_IDX_RELOAD_TIMER_CONTROL);
	assign wr_vl = wr & (idx == RCT_IDX_RELOAD_VALUE_LOW);
	assign wr_vh = wr & (idx == RCT_IDX_RELOAD_VALUE_HIGH);
	assign wr_cl = wr & (idx == RCT_IDX_RELOAD_COUNT_LOW);
	assign wr_ch = wr & (idx == RCT_IDX_RELOAD_COUNT_HIGH);
	assign wr_aux = wr & (idx == RCT_IDX_AUXILIARY_CONTROL);

	// Edge events from synchronised pins (second and third stages only)
	logic slow_edge;
	logic slow16_tick;
	logic trig_fall;
	logic cnt_fall;
	logic second_fall;

	assign slow_edge = st.slow_sync[1] & ~st.slow_sync[2]; // RULE_14
	assign slow16_tick = slow_edge & (st.slow_div == RCT_SLOW_DIV_LAST);
	assign trig_fall = ~st.trig_sync[1] & st.trig_sync[2];
	assign cnt_fall = ~st.cnt_sync[1] & st.cnt_sync[2];
	assign second_fall = ~st.second_sync[1] & st.second_sync[2];

	// Reload timer events
	logic serial_mode;
	logic capture_mode;
	logic cnt_src;
	logic cnt_step;
	logic ovf;
	logic trig_act;

	assign serial_mode = st.ctl[RCT_B_RX_CLOCK_SELECT] | st.ctl[RCT_B_TX_CLOCK_SELECT];
	assign capture_mode = st.ctl[RCT_B_CAPTURE_SELECT] & ~serial_mode; // RULE_10
	assign cnt_src = st.aux[RCT_B_RELOAD_INPUT_SELECT] ? slow16_tick : cnt_fall; // RULE_12
	assign cnt_step = st.ctl[RCT_B_RUN]
		& (st.ctl[RCT_B_COUNT_SOURCE] ? cnt_src : st.prescale); // RULE_06 RULE_07
	assign ovf = cnt_step & (st.count == RCT_COUNT_MAX); // RULE_19
	assign trig_act = trig_fall & st.ctl[RCT_B_TRIGGER_ENABLE] & ~serial_mode; // RULE_05

	// Time-base period by rate code
	logic [16:0] tb_period;
	logic tb_hit;

	always_comb begin
		case (st.option[RCT_B_RATE_LSB+:2]) // RULE_15
			2'b00: tb_period = RCT_TB_PERIOD_0;
			2'b01: tb_period = RCT_TB_PERIOD_1;
			2'b10: tb_period = RCT_TB_PERIOD_2;
			default: tb_period = RCT_TB_PERIOD_3;
		endcase
	end

	// A shortened period after a rate change ends at once rather than wrapping
	assign tb_hit = slow_edge & ~st.aux[RCT_B_TIMEBASE_CLEAR]
		& ({1'b0, st.tb_count} >= (tb_period - 17'd1));

	// Read data mux
	logic [7:0] rd_byte;

	always_comb begin
		case (idx)
			RCT_IDX_OPTION_SETTINGS: rd_byte = st.option;
			RCT_IDX_INTERRUPT_FLAGS: rd_byte = st.interrupt_flags & RCT_FLAG_MASK;
			RCT_IDX_RELOAD_TIMER_CONTROL: rd_byte = st.ctl;
			RCT_IDX_RELOAD_VALUE_LOW: rd_byte = st.rcap[7:0];
			RCT_IDX_RELOAD_VALUE_HIGH: rd_byte = st.rcap[15:8];
			RCT_IDX_RELOAD_COUNT_LOW: rd_byte = st.count[7:0];
			RCT_IDX_RELOAD_COUNT_HIGH: rd_byte = st.count[15:8];
			RCT_IDX_AUXILIARY_CONTROL: rd_byte = st.aux;
			default: rd_byte = RCT_RST_BYTE;
		endcase
	end

	// Next state of the whole block
	always_comb begin
		next_st = st;

		// Two-stage synchronisers plus an edge history stage
		next_st.slow_sync = {st.slow_sync[1:0], slow_clock};
		next_st.trig_sync = {st.trig_sync[1:0], trigger_input_pin};
		next_st.cnt_sync = {st.cnt_sync[1:0], reload_count_pin};
		next_st.second_sync = {st.second_sync[1:0], second_count_pin};

		// Two-clock time base unit for timer mode
		next_st.prescale = ~st.prescale; // RULE_06

		// Slow clock divided by 16
		if (slow_edge) begin
			next_st.slow_div = st.slow_div + 4'h1;
		end

		// Capture of the running count
		if (trig_act & capture_mode) begin
			next_st.rcap = st.count; // RULE_09 RULE_11
		end

		// Counting, overflow reload and trigger reload
		if (ovf) begin
			next_st.count = capture_mode ? RCT_RST_WORD : st.rcap; // RULE_08 RULE_10 RULE_11
		end else if (cnt_step) begin
			next_st.count = st.count + 16'h0001; // RULE_19
		end
		if (trig_act & ~capture_mode) begin
			next_st.count = st.rcap; // RULE_08
		end

		// Software writes to the data registers win over the hardware
		if (wr_vl) begin
			next_st.rcap[7:0] = apb_req.pwdata[7:0];
		end
		if (wr_vh) begin
			next_st.rcap[15:8] = apb_req.pwdata[7:0];
		end
		if (wr_cl) begin
			next_st.count[7:0] = apb_req.pwdata[7:0];
		end
		if (wr_ch) begin
			next_st.count[15:8] = apb_req.pwdata[7:0];
		end

		// Control register; hardware flag sets win over a clearing write
		if (wr_ctl) begin
			next_st.ctl = apb_req.pwdata[7:0];
		end
		if (ovf & ~serial_mode) begin
			next_st.ctl[RCT_B_OVERFLOW_FLAG] = 1'b1; // RULE_01
		end
		if (trig_act) begin
			next_st.ctl[RCT_B_TRIGGER_FLAG] = 1'b1; // RULE_02
		end

		// Option and auxiliary registers; time-base clear lasts one cycle
		if (wr_opt) begin
			next_st.option = apb_req.pwdata[7:0];
		end
		next_st.aux[RCT_B_TIMEBASE_CLEAR] = 1'b0; // RULE_18
		if (wr_aux) begin
			next_st.aux = apb_req.pwdata[7:0];
		end

		// Time-base counter
		if (st.aux[RCT_B_TIMEBASE_CLEAR] | tb_hit) begin
			next_st.tb_count = RCT_RST_WORD; // RULE_18
		end else if (slow_edge) begin
			next_st.tb_count = st.tb_count + 16'h0001; // RULE_14
		end

		// Interrupt flags: writing zero clears, writing one keeps, sets win
		if (wr_flg) begin
			next_st.interrupt_flags = st.interrupt_flags & (apb_req.pwdata[7:0] | ~RCT_FLAG_MASK); // RULE_17
		end
		if (timebase_isr_ack) begin
			next_st.interrupt_flags[RCT_B_TIMEBASE_FLAG] = 1'b0; // RULE_16
		end
		if (tb_hit) begin
			next_st.interrupt_flags[RCT_B_TIMEBASE_FLAG] = 1'b1; // RULE_16
		end
		if (other_flag_set[2]) begin
			next_st.interrupt_flags[RCT_B_TOUCH_FLAG] = 1'b1;
		end
		if (other_flag_set[1]) begin
			next_st.interrupt_flags[RCT_B_CONVERT_FLAG] = 1'b1;
		end
		if (other_flag_set[0]) begin
			next_st.interrupt_flags[RCT_B_PORT_FLAG] = 1'b1;
		end
		next_st.interrupt_flags = next_st.interrupt_flags & RCT_FLAG_MASK;

		// Buzzer waveform
		if (ovf) begin
			next_st.buzzer = ~st.buzzer; // RULE_20
		end

		// Serial clock selection
		next_st.rx_clk = st.ctl[RCT_B_RX_CLOCK_SELECT] ? ovf : second_timer_overflow; // RULE_03
		next_st.tx_clk = st.ctl[RCT_B_TX_CLOCK_SELECT] ? ovf : second_timer_overflow; // RULE_04

		// Baud ticks: reload overflow divided by 16
		next_st.rx_baud = 1'b0;
		next_st.tx_baud = 1'b0;
		if (ovf & st.ctl[RCT_B_RX_CLOCK_SELECT]) begin
			next_st.rx_div = st.rx_div + 4'h1;
			next_st.rx_baud = (st.rx_div == BAUD_LAST); // RULE_21
		end
		if (ovf & st.ctl[RCT_B_TX_CLOCK_SELECT]) begin
			next_st.tx_div = st.tx_div + 4'h1;
			next_st.tx_baud = (st.tx_div == BAUD_LAST); // RULE_21
		end

		// Second timer count source
		next_st.second_tick = st.aux[RCT_B_SECOND_INPUT_SELECT] ? slow16_tick
			: second_fall; // RULE_13

		// Read data captured in the setup phase
		if (rd_setup) begin
			next_st.prdata = {24'h000000, rd_byte};
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign apb_rsp.prdata = st.prdata;
	assign apb_rsp.pready = access;
	assign apb_rsp.pslverr = access & ~hit;
	assign serial_rx_clock = st.rx_clk;
	assign serial_tx_clock = st.tx_clk;
	assign serial_rx_baud = st.rx_baud;
	assign serial_tx_baud = st.tx_baud;
	assign second_count_tick = st.second_tick;
	assign buzzer_wave_output = st.buzzer;
	assign reload_overflow_flag = st.ctl[RCT_B_OVERFLOW_FLAG];
	assign external_trigger_flag = st.ctl[RCT_B_TRIGGER_FLAG];
	assign timebase_flag = st.interrupt_flags[RCT_B_TIMEBASE_FLAG];

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_ovf_flag;
		ovf && !serial_mode |=> reload_overflow_flag;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set"); // RULE_01

	property p_no_flag_serial;
		serial_mode && !wr_ctl |=> !$rose(reload_overflow_flag);
	endproperty
	a_no_flag_serial: assert property (p_no_flag_serial) else $error("flag in serial mode"); // RULE_01

	property p_trig_flag;
		trig_act |=> external_trigger_flag;
	endproperty
	a_trig_flag: assert property (p_trig_flag) else $error("trigger flag not set"); // RULE_02

	property p_rx_sel;
		st.ctl[RCT_B_RX_CLOCK_SELECT] && ovf |=> serial_rx_clock;
	endproperty
	a_rx_sel: assert property (p_rx_sel) else $error("receive clock not from overflow"); // RULE_03

	property p_tx_sel;
		!st.ctl[RCT_B_TX_CLOCK_SELECT] && !wr_ctl ##0 second_timer_overflow |=> serial_tx_clock;
	endproperty
	a_tx_sel: assert property (p_tx_sel) else $error("transmit clock not second timer"); // RULE_04

	property p_trig_gate;
		serial_mode && !wr_ctl |=> !$rose(external_trigger_flag);
	endproperty
	a_trig_gate: assert property (p_trig_gate) else $error("trigger acted in serial mode"); // RULE_05

	property p_timer_rate;
		st.ctl[RCT_B_RUN] && !st.ctl[RCT_B_COUNT_SOURCE] && !wr && !trig_act
			&& st.count < 16'hFFFE ##1 !wr && !trig_act && $stable(st.ctl)
			|=> st.count == $past(st.count, 2) + 16'h0001;
	endproperty
	a_timer_rate: assert property (p_timer_rate) else $error("timer rate not half clock"); // RULE_06

	property p_hold;
		!st.ctl[RCT_B_RUN] && !wr && !trig_act |=> $stable(st.count);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved while stopped"); // RULE_06

	property p_count_mode;
		st.ctl[RCT_B_RUN] && st.ctl[RCT_B_COUNT_SOURCE] && !cnt_src && !wr && !trig_act
			|=> $stable(st.count);
	endproperty
	a_count_mode: assert property (p_count_mode) else $error("counted without edge"); // RULE_07

	property p_reload;
		trig_act && !capture_mode && !wr |=> st.count == $past(st.rcap);
	endproperty
	a_reload: assert property (p_reload) else $error("trigger reload missed"); // RULE_08

	property p_capture;
		trig_act && capture_mode && !wr |=> st.rcap == $past(st.count);
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed"); // RULE_09

	property p_tb_clear;
		wr_aux && apb_req.pwdata[RCT_B_TIMEBASE_CLEAR] |=> ##1
			!st.aux[RCT_B_TIMEBASE_CLEAR] && st.tb_count == 16'h0000;
	endproperty
	a_tb_clear: assert property (p_tb_clear) else $error("time-base clear failed"); // RULE_18

	property p_tb_flag;
		tb_hit |=> timebase_flag && st.tb_count == 16'h0000;
	endproperty
	a_tb_flag: assert property (p_tb_flag) else $error("time-base flag not set"); // RULE_16

	property p_buzzer;
		ovf |=> buzzer_wave_output != $past(buzzer_wave_output);
	endproperty
	a_buzzer: assert property (p_buzzer) else $error("buzzer did not toggle"); // RULE_20

endmodule // rct_timers

/* include/rct_pkg.sv */
// Package for the reload/capture timer and the time-base timer: map, fields, types
package rct_pkg;

	// APB address width and register word indices (byte address is four times the index)
	localparam int RCT_ADDR_W = 12;
	localparam logic [9:0] RCT_IDX_OPTION_SETTINGS = 10'h094;
	localparam logic [9:0] RCT_IDX_INTERRUPT_FLAGS = 10'h095;
	localparam logic [9:0] RCT_IDX_RELOAD_TIMER_CONTROL = 10'h0C8;
	localparam logic [9:0] RCT_IDX_RELOAD_VALUE_LOW = 10'h0CA;
	localparam logic [9:0] RCT_IDX_RELOAD_VALUE_HIGH = 10'h0CB;
	localparam logic [9:0] RCT_IDX_RELOAD_COUNT_LOW = 10'h0CC;
	localparam logic [9:0] RCT_IDX_RELOAD_COUNT_HIGH = 10'h0CD;
	localparam logic [9:0] RCT_IDX_AUXILIARY_CONTROL = 10'h0F8;

	// Reload timer control fields
	localparam int RCT_B_OVERFLOW_FLAG = 7;
	localparam int RCT_B_TRIGGER_FLAG = 6;
	localparam int RCT_B_RX_CLOCK_SELECT = 5;
	localparam int RCT_B_TX_CLOCK_SELECT = 4;
	localparam int RCT_B_TRIGGER_ENABLE = 3;
	localparam int RCT_B_RUN = 2;
	localparam int RCT_B_COUNT_SOURCE = 1;
	localparam int RCT_B_CAPTURE_SELECT = 0;

	// Auxiliary control fields
	localparam int RCT_B_TIMEBASE_CLEAR = 6;
	localparam int RCT_B_RELOAD_INPUT_SELECT = 2;
	localparam int RCT_B_SECOND_INPUT_SELECT = 1;

	// Option field and interrupt flag fields
	localparam int RCT_B_RATE_LSB = 0;
	localparam int RCT_B_TIMEBASE_FLAG = 0;
	localparam int RCT_B_TOUCH_FLAG = 5;
	localparam int RCT_B_CONVERT_FLAG = 4;
	localparam int RCT_B_PORT_FLAG = 1;
	localparam logic [7:0] RCT_FLAG_MASK = 8'h33;

	// Reset values
	localparam logic [7:0] RCT_RST_BYTE = 8'h00;
	localparam logic [15:0] RCT_RST_WORD = 16'h0000;

	// Counts: divider terminal values and time-base periods in slow clock cycles
	localparam logic [15:0] RCT_COUNT_MAX = 16'hFFFF;
	localparam logic [3:0] RCT_SLOW_DIV_LAST = 4'hF;
	localparam logic [3:0] RCT_BAUD_DIV_LAST = 4'hF;
	localparam logic [16:0] RCT_TB_PERIOD_0 = 17'd32768;
	localparam logic [16:0] RCT_TB_PERIOD_1 = 17'd16384;
	localparam logic [16:0] RCT_TB_PERIOD_2 = 17'd8192;
	localparam logic [16:0] RCT_TB_PERIOD_3 = 17'd128;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [RCT_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} rct_apb_req_t;

	// APB answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rct_apb_rsp_t;

	// Whole state of the timer block
	typedef struct packed {
		logic [2:0] slow_sync;
		logic [2:0] trig_sync;
		logic [2:0] cnt_sync;
		logic [2:0] second_sync;
		logic prescale;
		logic [15:0] count;
		logic [15:0] rcap;
		logic [7:0] ctl;
		logic [7:0] aux;
		logic [7:0] option;
		logic [7:0] interrupt_flags;
		logic [3:0] slow_div;
		logic [15:0] tb_count;
		logic buzzer;
		logic [3:0] rx_div;
		logic [3:0] tx_div;
		logic rx_clk;
		logic tx_clk;
		logic rx_baud;
		logic tx_baud;
		logic second_tick;
		logic [31:0] prdata;
	} rct_state_t;

endpackage

/* test/rct_timers_tb.sv */
// Self-checking testbench for the reload/capture timer and the time-base timer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s expected %0h seen %0h", nm, (e), (g)); end end

module rct_timers_tb
	import rct_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	rct_apb_req_t req;
	rct_apb_rsp_t rsp;
	logic slow_clock;
	logic [2:0] pins; // Trigger, reload count and second count pins
	logic sovf;
	logic ack;
	logic [2:0] oset;
	logic rxc, txc, rxb, txb, stick, buz, ovf_f, trg_f, tb_f;
	logic buz_q = 1'b0;
	int error_cnt = 0;
	int samples_checked = 0;
	int n_rx = 0, n_tx = 0, n_rxb = 0, n_txb = 0, n_st = 0, n_buz = 0;
	logic [9:0] map_idx [8] = '{RCT_IDX_OPTION_SETTINGS, RCT_IDX_INTERRUPT_FLAGS,
		RCT_IDX_RELOAD_TIMER_CONTROL, RCT_IDX_RELOAD_VALUE_LOW, RCT_IDX_RELOAD_VALUE_HIGH,
		RCT_IDX_RELOAD_COUNT_LOW, RCT_IDX_RELOAD_COUNT_HIGH, RCT_IDX_AUXILIARY_CONTROL};
	logic [7:0] trig_cfg [4] = '{8'h09, 8'h08, 8'h18, 8'h01};

	// Clock at 20 MHz
	always #25 clk = ~clk;

	rct_timers dut (
		.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .slow_clock(slow_clock),
		.trigger_input_pin(pins[0]), .reload_count_pin(pins[1]), .second_count_pin(pins[2]),
		.second_timer_overflow(sovf), .timebase_isr_ack(ack), .other_flag_set(oset),
		.serial_rx_clock(rxc), .serial_tx_clock(txc), .serial_rx_baud(rxb),
		.serial_tx_baud(txb), .second_count_tick(stick), .buzzer_wave_output(buz),
		.reload_overflow_flag(ovf_f), .external_trigger_flag(trg_f), .timebase_flag(tb_f)
	);

	// Counts pulses and buzzer toggles seen on the outputs
	always @(posedge clk) begin
		if (rxc === 1'b1) n_rx++;
		if (txc === 1'b1) n_tx++;
		if (rxb === 1'b1) n_rxb++;
		if (txb === 1'b1) n_txb++;
		if (stick === 1'b1) n_st++;
		if (buz !== buz_q) n_buz++;
		buz_q = buz;
	end

	// Prints the counts and the verdict, then stops
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One APB transfer: setup, then access until pready
	task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int i;
		@(posedge clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= {idx, 2'b00};
		req.pwdata <= {24'($urandom), wd};
		@(posedge clk);
		req.penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (rsp.pready === 1'b1) break;
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (i == 16) begin
			error_cnt++;
			$display("wrong value apb ready expected 1 seen 0");
			close_out();
		end
	endtask

	task automatic reg_wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		xfer(1'b1, idx, d, r, e);
	endtask

	task automatic reg_rd(input logic [9:0] idx, output logic [31:0] r);
		logic e;
		xfer(1'b0, idx, 8'h00, r, e);
	endtask

	// Reads a 16-bit byte pair, low index first
	task automatic rd_pair(input logic [9:0] lo, output logic [15:0] v);
		logic [31:0] a;
		logic [31:0] b;
		reg_rd(lo, a);
		reg_rd(lo + 10'h001, b);
		v = {b[7:0], a[7:0]};
	endtask

	task automatic wr_pair(input logic [9:0] lo, input logic [15:0] v);
		reg_wr(lo, v[7:0]);
		reg_wr(lo + 10'h001, v[15:8]);
	endtask

	// One falling and rising edge on a pin, each level held five clocks
	task automatic fall(input int w);
		@(posedge clk);
		pins[w] <= 1'b0;
		repeat (5) @(posedge clk);
		pins[w] <= 1'b1;
		repeat (5) @(posedge clk);
	endtask

	// Slow clock periods of four system clocks
	task automatic slow_edges(input int n);
		repeat (n) begin
			@(posedge clk);
			slow_clock <= 1'b1;
			repeat (2) @(posedge clk);
			slow_clock <= 1'b0;
			@(posedge clk);
		end
	endtask

	// Main sequence
	initial begin
		logic [31:0] r;
		logic [15:0] c, c2, rc;
		logic [7:0] v, sel;
		logic e;
		int k, d_rx, d_tx, d_buz;
		req = '0;
		slow_clock = 1'b0;
		pins = 3'b111;
		sovf = 1'b0;
		ack = 1'b0;
		oset = 3'b000;
		void'($urandom(32'hB589));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		// Reset values, unmapped access, read/write registers
		foreach (map_idx[i]) begin
			reg_rd(map_idx[i], r);
			`CHK("reset value", 32'h0, r)
		end
		xfer(1'b0, 10'h000, 8'h00, r, e);
		`CHK("unmapped error", 1'b1, e)
		`CHK("unmapped data", 32'h0, r)
		for (int i = 3; i < 8; i++) begin
			v = 8'($urandom) & ((i == 7) ? 8'hBF : 8'hFF);
			reg_wr(map_idx[i], v);
			reg_rd(map_idx[i], r);
			`CHK("read back", {24'h0, v}, r)
		end
		reg_wr(RCT_IDX_AUXILIARY_CONTROL, 8'h00);
		$display("test done: registers");
		// Timer mode rate and hold
		wr_pair(RCT_IDX_RELOAD_COUNT_LOW, 16'h0000);
		reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, 8'h04);
		repeat (200) @(posedge clk);
		reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, 8'h00);
		rd_pair(RCT_IDX_RELOAD_COUNT_LOW, c);
		`CHK("timer rate", 1'b1, (c >= 16'd100 && c <= 16'd102))
		repeat (20) @(posedge clk);
		rd_pair(RCT_IDX_RELOAD_COUNT_LOW, c2);
		`CHK("stopped count", c, c2)
		$display("test done: timer rate");
		// Overflow sets the flag, reloads and toggles the buzzer
		rc = {8'hF0, 8'($urandom)};
		wr_pair(RCT_IDX_RELOAD_VALUE_LOW, rc);
		wr_pair(RCT_IDX_RELOAD_COUNT_LOW, 16'hFFF8);
		d_buz = n_buz;
		reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, 8'h04);
		repeat (30) @(posedge clk);
		// Flag read while running, so only the hardware can have set it
		reg_rd(RCT_IDX_RELOAD_TIMER_CONTROL, r);
		`CHK("overflow flag", 32'h84, r)
		`CHK("overflow flag out", 1'b1, ovf_f)
		reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, 8'h80);
		rd_pair(RCT_IDX_RELOAD_COUNT_LOW, c);
		`CHK("reloaded count", 1'b1, (c >= rc && c < rc + 16'd40))
		`CHK("buzzer toggles", 1, n_buz - d_buz)
		reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, 8'h00);
		@(posedge clk);
		`CHK("flag cleared", 1'b0, ovf_f)
		$display("test done: overflow");
		// Serial clock selects: receive then transmit
		for (int s = 0; s < 2; s++) begin
			sel = (s == 0) ? 8'h20 : 8'h10;
			wr_pair(RCT_IDX_RELOAD_VALUE_LOW, 16'hFFFC);
			wr_pair(RCT_IDX_RELOAD_COUNT_LOW, 16'hFFF8);
			d_rx = n_rx;
			d_tx = n_tx;
			d_buz = n_buz;
			k = (s == 0) ? n_rxb : n_txb;
			reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, sel | 8'h05);
			repeat (300) @(posedge clk);
			reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, sel | 8'h01);
			repeat (4) @(posedge clk);
			reg_rd(RCT_IDX_RELOAD_TIMER_CONTROL, r);
			`CHK("no flag in serial mode", {24'h0, sel | 8'h01}, r)
			rd_pair(RCT_IDX_RELOAD_COUNT_LOW, c);
			`CHK("forced reload", 1'b1, (c >= 16'hFFFC))
			d_rx = n_rx - d_rx;
			d_tx = n_tx - d_tx;
			d_buz = n_buz - d_buz;
			`CHK("selected clock", d_buz, (s == 0) ? d_rx : d_tx)
			`CHK("other clock", 0, (s == 0) ? d_tx : d_rx)
			`CHK("baud ticks", d_buz / 16, ((s == 0) ? n_rxb : n_txb) - k)
		end
		reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, 8'h00);
		d_rx = n_rx;
		d_tx = n_tx;
		@(posedge clk) sovf <= 1'b1;
		@(posedge clk) sovf <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK("second overflow rx", 1, n_rx - d_rx)
		`CHK("second overflow tx", 1, n_tx - d_tx)
		$display("test done: serial clocks");
		// Trigger pin: capture, reload, blocked by serial select, disabled
		foreach (trig_cfg[i]) begin
			c = 16'($urandom);
			rc = 16'($urandom);
			wr_pair(RCT_IDX_RELOAD_COUNT_LOW, c);
			wr_pair(RCT_IDX_RELOAD_VALUE_LOW, rc);
			reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, trig_cfg[i]);
			fall(0);
			rd_pair(RCT_IDX_RELOAD_COUNT_LOW, c2);
			`CHK("count after trigger", (i == 1) ? rc : c, c2)
			rd_pair(RCT_IDX_RELOAD_VALUE_LOW, c2);
			`CHK("capture after trigger", (i == 0) ? c : rc, c2)
			`CHK("trigger flag", (i < 2), trg_f)
		end
		$display("test done: trigger");
		// Counter mode from the count pin and from the slow clock over 16
		reg_wr(RCT_IDX_AUXILIARY_CONTROL, 8'h00);
		reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, 8'h06);
		rd_pair(RCT_IDX_RELOAD_COUNT_LOW, c);
		k = $urandom_range(3, 9);
		repeat (k) fall(1);
		rd_pair(RCT_IDX_RELOAD_COUNT_LOW, c2);
		`CHK("pin count", c + 16'(k), c2)
		d_rx = n_st;
		repeat (k) fall(2);
		`CHK("second pin ticks", k, n_st - d_rx)
		reg_wr(RCT_IDX_AUXILIARY_CONTROL, 8'h06);
		rd_pair(RCT_IDX_RELOAD_COUNT_LOW, c);
		d_rx = n_st;
		slow_edges(32);
		rd_pair(RCT_IDX_RELOAD_COUNT_LOW, c2);
		`CHK("slow count", c + 16'd2, c2)
		`CHK("second slow ticks", 2, n_st - d_rx)
		reg_wr(RCT_IDX_RELOAD_TIMER_CONTROL, 8'h00);
		$display("test done: counter mode");
		// Time-base: clear, period 128, flag clears by write and by service entry
		reg_wr(RCT_IDX_OPTION_SETTINGS, 8'h03);
		reg_wr(RCT_IDX_AUXILIARY_CONTROL, 8'h40);
		slow_edges(100);
		reg_wr(RCT_IDX_AUXILIARY_CONTROL, 8'h40);
		reg_rd(RCT_IDX_AUXILIARY_CONTROL, r);
		`CHK("clear bit returns", 32'h0, r)
		slow_edges(127);
		repeat (6) @(posedge clk);
		`CHK("time-base early", 1'b0, tb_f)
		slow_edges(1);
		repeat (6) @(posedge clk);
		`CHK("time-base 128", 1'b1, tb_f)
		@(posedge clk) oset <= 3'b111;
		@(posedge clk) oset <= 3'b000;
		reg_rd(RCT_IDX_INTERRUPT_FLAGS, r);
		`CHK("all flags", 32'h33, r)
		reg_wr(RCT_IDX_INTERRUPT_FLAGS, 8'hFE);
		reg_rd(RCT_IDX_INTERRUPT_FLAGS, r);
		`CHK("flags after FE", 32'h32, r)
		slow_edges(128);
		repeat (6) @(posedge clk);
		`CHK("time-base again", 1'b1, tb_f)
		@(posedge clk) ack <= 1'b1;
		@(posedge clk) ack <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("service clears", 1'b0, tb_f)
		reg_wr(RCT_IDX_OPTION_SETTINGS, 8'h02);
		reg_wr(RCT_IDX_AUXILIARY_CONTROL, 8'h40);
		slow_edges(8191);
		repeat (6) @(posedge clk);
		`CHK("time-base early 8192", 1'b0, tb_f)
		slow_edges(1);
		repeat (6) @(posedge clk);
		`CHK("time-base 8192", 1'b1, tb_f)
		$display("test done: time-base");
		close_out();
	end
endmodule // rct_timers_tb
